// file: hw/sarcc_control.sv
// Conversion control and host port of an 8-bit successive-approximation converter.
// Assumes chip select, start and read strobes are synchronous to clock_i and that
// the comparator and ladder sit outside, driven by trial_o.
//
// Summary of operation
// - MSB first, eight steps in 64 clocks
// - Plain binary result, all ones full-scale
// - New start abandons conversion in progress
// - Start falling edge clears register and shifter
// - Select and start low hold reset
// - Conversion begins 1 to 8 clocks later
// - Start flop resets shifter, clears interrupt
// - Start clears only after set condition leaves
// - Marker leaving shifter loads output latch
// - Next latch enable sets interrupt flop
// - Internal clocks eighth rate, eight-clock request
// - Read held low still shows interrupt
// - Free-run: interrupt wired to start input
// - Free-run interrupt pulse cut by restart
// - Select and read low clear, enable
// - Select, start, read are active low
`timescale 1ns/1ps

module sarcc_control (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Host control strobes, all active low
    input wire logic chip_select_n_i,
    input wire logic start_n_i,
    input wire logic read_n_i,
    // Comparator result for the current trial code
    input wire logic comparator_i,
    // Trial code towards the ladder switches
    output logic [sarcc_pkg::RES_W-1:0] trial_o,
    // Three-state result bus
    output logic [sarcc_pkg::RES_W-1:0] data_o,
    output logic data_oe_o,
    // End of conversion, active low
    output logic conversion_done_n_o,
    // Conversion in progress
    output logic busy_o
);
    import sarcc_pkg::*;

    // ************************************************************
    // State
    // ************************************************************

    typedef struct packed {
        sarcc_state_t state;
        logic [NOTE_W-1:0] note_cnt;
        logic done_n;
        logic [RES_W-1:0] data;
        logic data_oe;
        logic start_n_prev;
        logic start_fall;
        logic busy;
    } sarcc_ctl_st_t;

    sarcc_ctl_st_t st_q;
    sarcc_ctl_st_t st_d;

    logic tick;
    logic core_done;
    logic [RES_W-1:0] core_result;
    logic [RES_W-1:0] core_trial;
    logic set_cond;
    logic read_en;
    logic core_hold;

    // ************************************************************
    // Decoded host conditions
    // ************************************************************

    // Both strobes are active low; select must coincide with the strobe
    assign set_cond = !chip_select_n_i && !start_n_i;
    assign read_en = !chip_select_n_i && !read_n_i;
    // The start flop is the hold state; the shifter sits in reset meanwhile
    assign core_hold = (st_q.state == SARCC_ST_HOLD);

    // ************************************************************
    // Internal clocking and search datapath
    // ************************************************************

    // Divide-by-eight phase; every step of the search waits for a tick
    sarcc_phase_gen u_phase (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .tick_o(tick)
    );

    // Approximation register with its marker shifter
    sarcc_sar_core u_core (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .tick_i(tick),
        .hold_i(core_hold),
        .clear_i(st_q.start_fall),
        .comparator_i(comparator_i),
        .trial_o(core_trial),
        .result_o(core_result),
        .entry_o(),
        .done_o(core_done)
    );

    // ************************************************************
    // Sequencer
    // ************************************************************

    // Next-state logic; a start request overrides every other state
    always_comb begin
        st_d = st_q;
        st_d.start_n_prev = start_n_i;
        // Falling edge of start clears the search even with select high
        st_d.start_fall = st_q.start_n_prev && !start_n_i;
        st_d.data_oe = read_en;

        case (st_q.state)
            SARCC_ST_IDLE: begin
                st_d.note_cnt = NOTE_RST;
            end
            SARCC_ST_HOLD: begin
                // Release at the first internal tick after the set condition
                // has gone; the entry flop takes its one at that same tick, so
                // even a one-clock strobe starts within one internal period
                if (tick && !set_cond) begin
                    st_d.state = SARCC_ST_SEARCH;
                end
            end
            SARCC_ST_SEARCH: begin
                if (core_done) begin
                    st_d.data = core_result;
                    st_d.state = SARCC_ST_XFER;
                end
            end
            SARCC_ST_XFER: begin
                // The end-of-search latch is enabled by the next internal clock
                if (tick) begin
                    st_d.state = SARCC_ST_NOTIFY;
                    st_d.note_cnt = NOTE_RST;
                end
            end
            SARCC_ST_NOTIFY: begin
                // Set request stands for one internal period
                st_d.note_cnt = st_q.note_cnt + 3'h1;
                if (st_q.note_cnt == SET_REQ_LAST) begin
                    st_d.state = SARCC_ST_IDLE;
                end
            end
            default: begin
                st_d.state = SARCC_ST_IDLE;
                st_d.note_cnt = NOTE_RST;
            end
        endcase

        // A bare falling start edge with select high leaves an empty shifter
        if (st_q.start_fall && !set_cond && (st_q.state == SARCC_ST_SEARCH)) begin
            st_d.state = SARCC_ST_IDLE;
        end

        // Select with start low sets the start flop from any state
        if (set_cond) begin
            st_d.state = SARCC_ST_HOLD;
            st_d.note_cnt = NOTE_RST;
        end

        // Interrupt flop: set request wins over the read clear, which is
        // what keeps the flag visible with the outputs always enabled.
        // A restart drops the set request, so in free-run mode the pulse
        // lasts only the one cycle the strobe takes to come round.
        if (st_d.state == SARCC_ST_NOTIFY) begin
            st_d.done_n = 1'b0;
        end else if (read_en || set_cond) begin
            st_d.done_n = 1'b1;
        end

        st_d.busy = (st_d.state == SARCC_ST_HOLD) || (st_d.state == SARCC_ST_SEARCH)
                    || (st_d.state == SARCC_ST_XFER);
    end

    // ************************************************************
    // State register
    // ************************************************************

    // Asynchronous reset puts the logic in the same rest state that a
    // power-up start pulse would reach
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '{state: SARCC_ST_IDLE, note_cnt: NOTE_RST, done_n: DONE_N_RST, data: RESULT_RST,
                      data_oe: 1'b0, start_n_prev: 1'b1, start_fall: 1'b0, busy: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // All outputs come straight from flops
    assign data_o = st_q.data;
    assign data_oe_o = st_q.data_oe;
    assign conversion_done_n_o = st_q.done_n;
    assign busy_o = st_q.busy;
    assign trial_o = core_trial;

endmodule // sarcc_control

// file: pkg/sarcc_pkg.sv
// Shared constants and types of the converter control block.
// Assumes one external clock; all control inputs arrive synchronous to it.

package sarcc_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int RES_W = 8;
    localparam int PHASE_W = 3;
    localparam int NOTE_W = 3;

    // ************************************************************
    // Timing
    // ************************************************************
    // External clock period in ns
    localparam int EXT_CLK_PERIOD_NS = 10;
    // Internal clocks run at one eighth of the external clock
    localparam int INT_CLK_DIV = 8;
    localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(INT_CLK_DIV - 1);
    // Interrupt set request lasts this many external clock periods
    localparam int SET_REQ_PERIODS = 8;
    localparam logic [NOTE_W-1:0] SET_REQ_LAST = NOTE_W'(SET_REQ_PERIODS - 1);

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [RES_W-1:0] RESULT_RST = 8'h00;
    localparam logic [PHASE_W-1:0] PHASE_RST = 3'h0;
    localparam logic [NOTE_W-1:0] NOTE_RST = 3'h0;
    localparam logic DONE_N_RST = 1'b1;

    // ************************************************************
    // Control sequencer states
    // ************************************************************
    typedef enum logic [4:0] {
        SARCC_ST_IDLE   = 5'b00001,
        SARCC_ST_HOLD   = 5'b00010,
        SARCC_ST_SEARCH = 5'b00100,
        SARCC_ST_XFER   = 5'b01000,
        SARCC_ST_NOTIFY = 5'b10000
    } sarcc_state_t;

    // Set the marked bit of the approximation word when the comparison keeps it
    function automatic logic [RES_W-1:0] sarcc_resolve(input logic [RES_W-1:0] word,
                                                       input logic [RES_W-1:0] marker,
                                                       input logic keep);
        sarcc_resolve = word | (marker & {RES_W{keep}});
    endfunction

endpackage

// file: hw/sarcc_phase_gen.sv
// Internal clock phase generator of the converter control block.
// Assumes clock_i is the external converter clock; emits one tick per eight.
`timescale 1ns/1ps

module sarcc_phase_gen (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Internal clock tick
    output logic tick_o
);
    import sarcc_pkg::*;

    typedef struct packed {
        logic [PHASE_W-1:0] phase;
        logic tick;
    } sarcc_phase_st_t;

    sarcc_phase_st_t st_q;
    sarcc_phase_st_t st_d;

    // Free-running divider; a tick stands in for one internal clock edge
    always_comb begin
        st_d = st_q;
        st_d.phase = st_q.phase + 3'h1;
        st_d.tick = (st_q.phase == PHASE_LAST);
    end

    // State register
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '{phase: PHASE_RST, tick: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign tick_o = st_q.tick;

endmodule // sarcc_phase_gen

// file: hw/sarcc_sar_core.sv
// Approximation register, marker shift register and entry flop.
// Assumes comparator_i reflects the ladder for trial_o at each tick.
`timescale 1ns/1ps

module sarcc_sar_core (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Sequencing
    input wire logic tick_i,
    input wire logic hold_i,
    input wire logic clear_i,
    // Comparator
    input wire logic comparator_i,
    // Results
    output logic [sarcc_pkg::RES_W-1:0] trial_o,
    output logic [sarcc_pkg::RES_W-1:0] result_o,
    output logic entry_o,
    output logic done_o
);
    import sarcc_pkg::*;

    typedef struct packed {
        logic entry;
        logic [RES_W-1:0] marker;
        logic [RES_W-1:0] approx;
        logic [RES_W-1:0] trial;
        logic done;
    } sarcc_core_st_t;

    sarcc_core_st_t st_q;
    sarcc_core_st_t st_d;

    // One comparison per internal tick, most significant bit first
    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        if (hold_i || clear_i) begin
            st_d.marker = RESULT_RST;
            st_d.approx = RESULT_RST;
            st_d.entry = hold_i && (st_q.entry || tick_i);
        end else if (tick_i) begin
            st_d.approx = sarcc_resolve(st_q.approx, st_q.marker, comparator_i);
            st_d.marker = {st_q.entry, st_q.marker[RES_W-1:1]};
            st_d.entry = 1'b0;
            st_d.done = st_q.marker[0];
        end
        // Ladder trial: settled bits plus the bit under test
        st_d.trial = st_d.approx | st_d.marker;
    end

    // State register
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '{entry: 1'b0, marker: RESULT_RST, approx: RESULT_RST, trial: RESULT_RST, done: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign trial_o = st_q.trial;
    assign result_o = st_q.approx;
    assign entry_o = st_q.entry;
    assign done_o = st_q.done;

endmodule // sarcc_sar_core

// file: test/sarcc_host_model.sv
// Far side model: ideal analog input, comparator and the shared data bus wire.
// Assumes trial_i, data_i and data_oe_i come straight from the control block.
`timescale 1ns/1ps

module sarcc_host_model (
    // Clock
    input wire logic clock_i,
    // Control block side
    input wire logic [sarcc_pkg::RES_W-1:0] trial_i,
    input wire logic [sarcc_pkg::RES_W-1:0] data_i,
    input wire logic data_oe_i,
    // Analog input given as its ideal code
    input wire logic [sarcc_pkg::RES_W-1:0] level_i,
    // Comparator and resolved bus
    output logic comparator_o,
    output logic [sarcc_pkg::RES_W-1:0] bus_o
);
    import sarcc_pkg::*;
    logic [RES_W-1:0] last_q = 8'h00;
    // Ideal comparator, keep the bit while the input reaches the trial code
    assign comparator_o = (level_i >= trial_i);
    // Remember the last driven byte
    always_ff @(posedge clock_i) begin
        if (data_oe_i) begin
            last_q <= data_i;
        end
    end
    // Released bus floats away from the last byte, so stale data never matches
    assign bus_o = data_oe_i ? data_i : ~last_q;
endmodule // sarcc_host_model

// file: test/sarcc_control_props.sv
// Concurrent checks on the ports of the converter control block.
// Assumes one clock domain; attached by the bind at the foot of this file.
`timescale 1ns/1ps

module sarcc_control_props (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Host strobes and comparator
    input wire logic chip_select_n_i,
    input wire logic start_n_i,
    input wire logic read_n_i,
    input wire logic comparator_i,
    // Outputs
    input wire logic [sarcc_pkg::RES_W-1:0] trial_o,
    input wire logic [sarcc_pkg::RES_W-1:0] data_o,
    input wire logic data_oe_o,
    input wire logic conversion_done_n_o,
    input wire logic busy_o
);
    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    chk_start_taken: assert property (!chip_select_n_i && !start_n_i |-> ##[1:2] busy_o && conversion_done_n_o)
        else $error("start not taken");
    chk_hold_reset: assert property ((!chip_select_n_i && !start_n_i)[*3] |-> trial_o == 8'h00 && busy_o)
        else $error("held start advanced");
    chk_msb_first: assert property (trial_o != 8'h00 && $past(trial_o) == 8'h00 |-> trial_o == 8'h80)
        else $error("first trial not top bit");
    chk_step_rate: assert property (trial_o == 8'h80 && $past(trial_o) == 8'h00 |-> ##7 !trial_o[6] ##1 trial_o[6])
        else $error("second trial not eight clocks later");
    chk_load_then_done: assert property ($changed(data_o) |-> ##[0:9] $fell(conversion_done_n_o))
        else $error("no end of conversion after load");
    chk_done_width: assert property ($fell(conversion_done_n_o) && start_n_i && !chip_select_n_i && !read_n_i
        |-> (!conversion_done_n_o)[*8] ##1 conversion_done_n_o)
        else $error("done pulse width");
    chk_done_held: assert property (!conversion_done_n_o && chip_select_n_i |=> !conversion_done_n_o)
        else $error("done dropped without read");
    chk_read_clear: assert property ((!chip_select_n_i && !read_n_i && !conversion_done_n_o)[*8] |=> conversion_done_n_o)
        else $error("read did not clear done");
    chk_oe_on_read: assert property (!chip_select_n_i && !read_n_i |=> data_oe_o)
        else $error("output not enabled");
    chk_oe_off: assert property (chip_select_n_i || read_n_i |=> !data_oe_o)
        else $error("output driven while deselected");
    // Main scenarios
    cov_done: cover property ($fell(conversion_done_n_o));
    cov_read: cover property (data_oe_o && !conversion_done_n_o);
    cov_short_done: cover property ($fell(conversion_done_n_o) ##2 conversion_done_n_o);
endmodule // sarcc_control_props

bind sarcc_control sarcc_control_props i_props (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .chip_select_n_i(chip_select_n_i), .start_n_i(start_n_i), .read_n_i(read_n_i),
    .comparator_i(comparator_i), .trial_o(trial_o), .data_o(data_o), .data_oe_o(data_oe_o),
    .conversion_done_n_o(conversion_done_n_o), .busy_o(busy_o));

// file: test/sar_adc_conversion_control_tb.sv
// Self-checking bench of the converter control block with the far side model.
// Assumes the checker is bound to the control block from its own file.
`timescale 1ns/1ps

module sar_adc_conversion_control_tb;
    import sarcc_pkg::*;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic chip_select_n_i = 1'b1;
    logic start_q = 1'b1;
    logic read_n_i = 1'b1;
    logic free_run = 1'b0;
    logic done_prev = 1'b1;
    logic [RES_W-1:0] level = 8'h00;
    logic start_n_i, comparator_i, data_oe_o, conversion_done_n_o, busy_o;
    logic [RES_W-1:0] trial_o, data_o, bus_lvl, v;
    logic [RES_W-1:0] exp_q[$];
    logic [RES_W-1:0] corner[4] = '{8'hff, 8'h00, 8'h80, 8'h7f};
    int err_count = 0;
    int checks_done = 0;
    int falls = 0;
    int n, f0;

    // ************************************************************
    // Clock, loop-back and instances
    // ************************************************************
    always #(EXT_CLK_PERIOD_NS / 2) clock_i = ~clock_i;
    assign start_n_i = free_run ? conversion_done_n_o : start_q;
    sarcc_control i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .chip_select_n_i(chip_select_n_i),
        .start_n_i(start_n_i), .read_n_i(read_n_i), .comparator_i(comparator_i), .trial_o(trial_o),
        .data_o(data_o), .data_oe_o(data_oe_o), .conversion_done_n_o(conversion_done_n_o), .busy_o(busy_o));
    sarcc_host_model i_host (.clock_i(clock_i), .trial_i(trial_o), .data_i(data_o), .data_oe_i(data_oe_o),
        .level_i(level), .comparator_o(comparator_i), .bus_o(bus_lvl));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic wrap_up();
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask
    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask
    // Bounded wait for the falling end of conversion
    task automatic wait_done(output int cyc);
        cyc = 0;
        while (conversion_done_n_o !== 1'b0 && cyc < 200) begin
            step(1);
            cyc++;
        end
        if (cyc >= 200) begin
            check(1'b0, "no end of conversion");
            wrap_up();
        end
    endtask
    // Start strobe one clock longer than the given width, with select; note the expected code
    task automatic convert(input logic [RES_W-1:0] val, input int width);
        int cyc;
        level = val;
        exp_q.push_back(val);
        chip_select_n_i = 1'b0;
        start_q = 1'b0;
        step(width + 1);
        check(busy_o === 1'b1 && conversion_done_n_o === 1'b1, "start not taken");
        check(trial_o === 8'h00, "held start advanced");
        chip_select_n_i = 1'b1;
        start_q = 1'b1;
        wait_done(cyc);
        check(cyc >= 64 && cyc <= 90, "conversion length");
    endtask
    // Read cycle, with a deselected read first
    task automatic read_check(input logic [RES_W-1:0] val);
        read_n_i = 1'b0;
        step(2);
        check(data_oe_o === 1'b0, "driven without select");
        chip_select_n_i = 1'b0;
        step(2);
        check(data_oe_o === 1'b1 && bus_lvl === val, "read data");
        check(conversion_done_n_o === 1'b1, "read did not clear");
        read_n_i = 1'b1;
        step(2);
        check(data_oe_o === 1'b0 && bus_lvl !== val, "bus not released");
        chip_select_n_i = 1'b1;
    endtask

    // ************************************************************
    // Result watcher
    // ************************************************************
    always @(posedge clock_i) begin
        #2;
        if (done_prev === 1'b1 && conversion_done_n_o === 1'b0) begin
            falls++;
            if (!free_run && exp_q.size() == 0) begin
                check(1'b0, "unexpected end of conversion");
            end else if (!free_run) begin
                check(data_o === exp_q.pop_front(), "result mismatch");
            end
        end
        done_prev = conversion_done_n_o;
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(85));
        repeat (2) @(posedge clock_i);
        #1;
        rst_b_i = 1'b1;
        // Corner codes, then random ones; the wide strobe at i == 2
        for (int i = 0; i < 7; i++) begin
            v = (i < 4) ? corner[i] : RES_W'($urandom);
            convert(v, (i == 2) ? 40 : i + 1);
            step(9);
            read_check(v);
        end
        step(20);
        read_check(v);
        // Restart in mid-search, only the second code may appear
        level = 8'h11;
        chip_select_n_i = 1'b0;
        start_q = 1'b0;
        step(1);
        chip_select_n_i = 1'b1;
        start_q = 1'b1;
        step(30);
        convert(8'h5a, 1);
        step(9);
        read_check(8'h5a);
        // Falling start with select high drops a running search, no result
        level = 8'h99;
        chip_select_n_i = 1'b0;
        start_q = 1'b0;
        step(1);
        chip_select_n_i = 1'b1;
        start_q = 1'b1;
        step(30);
        start_q = 1'b0;
        step(2);
        check(busy_o === 1'b0 && trial_o === 8'h00, "search not dropped");
        start_q = 1'b1;
        step(100);
        read_check(8'h5a);
        // Read held low throughout still shows an eight clock done pulse
        exp_q.push_back(8'hc3);
        level = 8'hc3;
        chip_select_n_i = 1'b0;
        read_n_i = 1'b0;
        start_q = 1'b0;
        step(2);
        start_q = 1'b1;
        wait_done(n);
        n = 0;
        while (conversion_done_n_o === 1'b0 && n < 20) begin
            step(1);
            n++;
        end
        check(n == SET_REQ_PERIODS && bus_lvl === 8'hc3, "held read done width");
        read_n_i = 1'b1;
        step(2);
        // Free running: done looped back to start with select low
        level = 8'h3c;
        start_q = 1'b0;
        step(2);
        start_q = 1'b1;
        free_run = 1'b1;
        f0 = falls;
        n = 0;
        repeat (300) begin
            step(1);
            n += (conversion_done_n_o === 1'b0) ? 1 : 0;
        end
        check(falls - f0 >= 3, "free run stalled");
        check(n <= 3 * (falls - f0), "free run done pulse too long");
        wrap_up();
    end
endmodule // sar_adc_conversion_control_tb
